// ==== logic/dcr_pkg.sv ====
package dcr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_ADC_RESULT = 8'h21;
  localparam logic [7:0] ADDR_LIMIT_BOOST = 8'ha1;
  localparam logic [7:0] ADDR_FAULT_MODE = 8'ha2;
  localparam logic [7:0] ADDR_DIAG_CH0 = 8'h31;
  localparam logic [7:0] ADDR_DIAG_STEP = 8'h10;
  localparam logic [7:0] ADDR_DIAG_GLOBAL = 8'h71;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int NUM_CH = 4;
  localparam int NUM_SUPPLY = 2;
  localparam int BOOST_W = 2;
  localparam int HOLD_BIT = 7;
  localparam int SEL_W = 3;
  localparam logic [7:0] FAULT_MODE_MASK = 8'h87;
  // ----------------------------------------
  // boost codes and percentages
  // ----------------------------------------
  localparam logic [1:0] BOOST_NONE = 2'h0;
  localparam logic [1:0] BOOST_30 = 2'h1;
  localparam logic [1:0] BOOST_60 = 2'h2;
  localparam logic [1:0] BOOST_100 = 2'h3;
  localparam logic [6:0] PCT_NONE = 7'h00;
  localparam logic [6:0] PCT_30 = 7'h1e;
  localparam logic [6:0] PCT_60 = 7'h3c;
  localparam logic [6:0] PCT_100 = 7'h64;
  // ----------------------------------------
  // limit source per channel
  // ----------------------------------------
  typedef enum logic [1:0] {
    DCR_LIM_BASELINE = 2'h0,
    DCR_LIM_LOW_DEFAULT = 2'h1,
    DCR_LIM_HIGH_DEFAULT = 2'h3
  } dcr_limit_src_t;
  // ----------------------------------------
  // selector codes
  // ----------------------------------------
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_CH_LAST = 3'h4;
  localparam logic [2:0] SEL_EXT_PIN = 3'h5;
endpackage

// ==== logic/dcr_regs.sv ====
`timescale 1ns/1ps

// How it works
// - two-bit boost per output: 0/30/60/100 percent
// - each boost scales only its own channel
// - limit boost reads back what was written; fault mode reads back with bits 6:3 cleared
// - reset or wake clears all three registers
// - open resistor low default, shorted resistor high
// - resistor fault disables every channel's boost
// - hold mode off: flags follow live faults
// - hold mode on: flag stays until read
// - hold mode covers all non-latched flags together
// - output off during fault, back on afterwards
// - live driver and supply fault status reported
// - open-load selector: 0 off, 1-4 channel, else none
// - open-load check on at most one channel
// - adc result register ignores host writes
// - adc register returns latest conversion result taken while sense selector is not 0
// - sense selector: 0 off, 1-4 channel, 5 pin
// - reading without hold mode clears nothing
module dcr_regs
  import dcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wake,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic limit_res_open,
  input wire logic limit_res_short,
  output logic [dcr_pkg::NUM_CH-1:0][6:0] boost_pct,
  output logic [dcr_pkg::NUM_CH-1:0][1:0] limit_src,
  input wire logic [dcr_pkg::NUM_CH-1:0] battery_short_live,
  input wire logic [dcr_pkg::NUM_CH-1:0] open_load_live,
  input wire logic [dcr_pkg::NUM_CH-1:0] thermal_warning_live,
  input wire logic [dcr_pkg::NUM_SUPPLY-1:0] supply_low_live,
  input wire logic [dcr_pkg::NUM_SUPPLY-1:0] supply_high_live,
  output logic [dcr_pkg::NUM_CH-1:0] battery_short_flag,
  output logic [dcr_pkg::NUM_CH-1:0] open_load_flag,
  output logic [dcr_pkg::NUM_CH-1:0] thermal_warning_flag,
  output logic [dcr_pkg::NUM_SUPPLY-1:0] supply_low_flag,
  output logic [dcr_pkg::NUM_SUPPLY-1:0] supply_high_flag,
  output logic [dcr_pkg::NUM_CH-1:0] output_allow,
  output logic [dcr_pkg::NUM_CH-1:0] open_load_channel_select,
  input wire logic [2:0] sense_select,
  output logic [dcr_pkg::NUM_CH-1:0] sense_channel,
  output logic sense_ext_pin,
  output logic adc_enable,
  input wire logic adc_done,
  input wire logic [7:0] adc_data
);
  import dcr_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // codes 1..4 pick one channel; anything else picks none
  function automatic logic [NUM_CH-1:0] sel_onehot(input logic [2:0] code);
    logic [NUM_CH-1:0] r;
    r = '0;
    if (code != SEL_OFF && code <= SEL_CH_LAST)
    begin
      r[code[1:0] - 2'h1] = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [6:0] boost_to_pct(input logic [1:0] code);
    logic [6:0] r;
    unique case (code)
      BOOST_NONE: r = PCT_NONE;
      BOOST_30: r = PCT_30;
      BOOST_60: r = PCT_60;
      BOOST_100: r = PCT_100;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] limit_boost;
  logic [7:0] fault_mode;
  logic [7:0] adc_result;
  logic [7:0] next_limit_boost;
  logic [7:0] next_fault_mode;
  logic [7:0] next_adc_result;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic clear_all;
  logic flag_hold_until_read;
  logic [NUM_CH-1:0] clr_ch;
  logic clr_global;

  assign clear_all = !rst_b || wake;
  assign flag_hold_until_read = fault_mode[HOLD_BIT];

  always_comb
  begin
    next_limit_boost = limit_boost;
    next_fault_mode = fault_mode;
    next_adc_result = adc_result;
    next_reg_rdata = reg_rdata;
    next_reg_rvalid = 1'b0;
    if (reg_wr && reg_addr == ADDR_LIMIT_BOOST)
    begin
      next_limit_boost = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_FAULT_MODE)
    begin
      next_fault_mode = reg_wdata & FAULT_MODE_MASK;
    end
    // a conversion with the sense selector at 0 (off) is stale, so it is dropped
    if (adc_done && sense_select != SEL_OFF)
    begin
      next_adc_result = adc_data;
    end
    if (reg_rd)
    begin
      next_reg_rvalid = 1'b1;
      unique case (reg_addr)
        ADDR_LIMIT_BOOST: next_reg_rdata = limit_boost;
        ADDR_FAULT_MODE: next_reg_rdata = fault_mode;
        ADDR_ADC_RESULT: next_reg_rdata = adc_result;
        default: next_reg_rdata = READ_UNMAPPED;
      endcase
    end
    if (clear_all)
    begin
      next_limit_boost = RESET_VALUE;
      next_fault_mode = RESET_VALUE;
      next_adc_result = RESET_VALUE;
      next_reg_rdata = RESET_VALUE;
      next_reg_rvalid = 1'b0;
    end
  end

  // adc_result has no host write path; only conversions, reset and wake load it
  always_ff @(posedge clk_sys)
  begin
    limit_boost <= next_limit_boost;
    fault_mode <= next_fault_mode;
    adc_result <= next_adc_result;
    reg_rdata <= next_reg_rdata;
    reg_rvalid <= next_reg_rvalid;
  end

  // ----------------------------------------
  // per-channel limit, flags and output gating
  // ----------------------------------------
  assign clr_global = reg_rd && reg_addr == ADDR_DIAG_GLOBAL;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic [6:0] next_pct;
      logic [1:0] next_src;
      logic [2:0] next_flags;
      logic [2:0] live;
      logic [2:0] held;
      logic next_allow;
      assign clr_ch[ch] = reg_rd && reg_addr == ADDR_DIAG_CH0 + 8'(ch) * ADDR_DIAG_STEP;
      assign live = {battery_short_live[ch], open_load_live[ch], thermal_warning_live[ch]};
      assign held = {battery_short_flag[ch], open_load_flag[ch], thermal_warning_flag[ch]};
      always_comb
      begin
        next_pct = boost_to_pct(limit_boost[ch*BOOST_W +: BOOST_W]);
        next_src = DCR_LIM_BASELINE;
        if (limit_res_open)
        begin
          next_src = DCR_LIM_LOW_DEFAULT;
        end
        else if (limit_res_short)
        begin
          next_src = DCR_LIM_HIGH_DEFAULT;
        end
        if (limit_res_open || limit_res_short)
        begin
          next_pct = PCT_NONE;
        end
        // a new event in the read cycle survives the clear
        if (flag_hold_until_read)
        begin
          next_flags = (held & ~{3{clr_ch[ch]}}) | live;
        end
        else
        begin
          next_flags = live;
        end
        next_allow = !(|live);
        if (!rst_b)
        begin
          next_pct = PCT_NONE;
          next_src = DCR_LIM_BASELINE;
          next_flags = '0;
          next_allow = 1'b0;
        end
      end
      always_ff @(posedge clk_sys)
      begin
        boost_pct[ch] <= next_pct;
        limit_src[ch] <= next_src;
        {battery_short_flag[ch], open_load_flag[ch], thermal_warning_flag[ch]} <= next_flags;
        output_allow[ch] <= next_allow;
      end
    end
  endgenerate

  // ----------------------------------------
  // supply flags and selectors
  // ----------------------------------------
  logic [NUM_SUPPLY-1:0] next_low;
  logic [NUM_SUPPLY-1:0] next_high;
  logic [NUM_CH-1:0] next_ol_sel;
  logic [NUM_CH-1:0] next_sense_ch;
  logic next_ext;
  logic next_adc_en;

  always_comb
  begin
    if (flag_hold_until_read)
    begin
      next_low = (supply_low_flag & ~{NUM_SUPPLY{clr_global}}) | supply_low_live;
      next_high = (supply_high_flag & ~{NUM_SUPPLY{clr_global}}) | supply_high_live;
    end
    else
    begin
      next_low = supply_low_live;
      next_high = supply_high_live;
    end
    // one shared current source: never more than one channel
    next_ol_sel = sel_onehot(fault_mode[SEL_W-1:0]);
    next_sense_ch = sel_onehot(sense_select);
    next_ext = sense_select == SEL_EXT_PIN;
    next_adc_en = sense_select != SEL_OFF && sense_select <= SEL_EXT_PIN;
    if (!rst_b)
    begin
      next_low = '0;
      next_high = '0;
      next_ol_sel = '0;
      next_sense_ch = '0;
      next_ext = 1'b0;
      next_adc_en = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    supply_low_flag <= next_low;
    supply_high_flag <= next_high;
    open_load_channel_select <= next_ol_sel;
    sense_channel <= next_sense_ch;
    sense_ext_pin <= next_ext;
    adc_enable <= next_adc_en;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_boost_pct;
    @(posedge clk_sys) disable iff (!rst_b)
    !limit_res_open && !limit_res_short && limit_boost[1:0] == BOOST_100 |=> boost_pct[0] == PCT_100;
  endproperty
  a_boost_pct: assert property (p_boost_pct) else $error("boost code 3 not 100 percent");

  property p_boost_indep;
    @(posedge clk_sys) disable iff (!rst_b)
    !limit_res_open && !limit_res_short && limit_boost[3:2] == BOOST_NONE |=> boost_pct[1] == PCT_NONE;
  endproperty
  a_boost_indep: assert property (p_boost_indep) else $error("channel boost leaked");

  property p_readback;
    @(posedge clk_sys) disable iff (!rst_b || wake)
    reg_wr && reg_addr == ADDR_LIMIT_BOOST ##1 !reg_wr ##1 reg_rd && reg_addr == ADDR_LIMIT_BOOST && !reg_wr
    |=> reg_rvalid && reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_readback: assert property (p_readback) else $error("boost readback mismatch");

  property p_wake_clear;
    @(posedge clk_sys) wake |=> limit_boost == RESET_VALUE && fault_mode == RESET_VALUE && adc_result == RESET_VALUE;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear");

  property p_failsafe;
    @(posedge clk_sys) disable iff (!rst_b)
    limit_res_open |=> limit_src[2] == DCR_LIM_LOW_DEFAULT && boost_pct[2] == PCT_NONE;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("open resistor failsafe wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    flag_hold_until_read && battery_short_live[0] ##1 (flag_hold_until_read && !clr_ch[0]) [*2]
    |=> battery_short_flag[0];
  endproperty
  a_hold: assert property (p_hold) else $error("held flag dropped");

  property p_follow;
    @(posedge clk_sys) disable iff (!rst_b)
    !flag_hold_until_read |=> open_load_flag[3] == $past(open_load_live[3]);
  endproperty
  a_follow: assert property (p_follow) else $error("flag not live");

  property p_allow;
    @(posedge clk_sys) disable iff (!rst_b)
    thermal_warning_live[1] ##1 !battery_short_live[1] && !open_load_live[1] && !thermal_warning_live[1]
    |-> !output_allow[1] ##1 output_allow[1];
  endproperty
  a_allow: assert property (p_allow) else $error("output not restored");

  property p_one_ol;
    @(posedge clk_sys) disable iff (!rst_b) $onehot0(open_load_channel_select);
  endproperty
  a_one_ol: assert property (p_one_ol) else $error("open-load on two channels");

  property p_adc_ro;
    @(posedge clk_sys) disable iff (!rst_b || wake)
    reg_wr && reg_addr == ADDR_ADC_RESULT && !adc_done |=> $stable(adc_result);
  endproperty
  a_adc_ro: assert property (p_adc_ro) else $error("adc result written");

  property p_pad_zero;
    @(posedge clk_sys) disable iff (!rst_b) fault_mode[6:3] == 4'h0;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("unused bits set");

  c_hold_clear: cover property (@(posedge clk_sys) flag_hold_until_read && battery_short_flag[0] ##1 clr_ch[0]);
  c_failsafe_short: cover property (@(posedge clk_sys) limit_res_short ##1 limit_src[0] == DCR_LIM_HIGH_DEFAULT);
  c_adc_read: cover property (@(posedge clk_sys) adc_done ##1 reg_rd && reg_addr == ADDR_ADC_RESULT);
endmodule // dcr_regs

// ==== sim/dcr_host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// host side of the register strobe port
// ----------------------------------------
module dcr_host_model
(
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // idle bus shows the inverse of the last value, so stale data never looks valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~addr;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule // dcr_host_model

// ==== sim/tb_dcr_regs.sv ====
`timescale 1ns/1ps

module tb_dcr_regs;
  import dcr_pkg::*;
  logic clk_sys, rst_b, wake, reg_wr, reg_rd, reg_rvalid, lim_open, lim_short;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, adc_data, rd;
  logic [3:0][6:0] boost_pct;
  logic [3:0][1:0] limit_src;
  logic [3:0] bs_live, ol_live, tw_live, bs_flag, ol_flag, tw_flag, allow, ol_sel, sense_ch;
  logic [1:0] lo_live, hi_live, lo_flag, hi_flag;
  logic [2:0] sense_select;
  logic sense_ext, adc_en, adc_done;
  int miscompares, comparisons, cycles;
  logic [7:0] pct [4] = '{8'h00, 8'h1e, 8'h3c, 8'h64};

  dcr_regs dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .wake(wake), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .limit_res_open(lim_open), .limit_res_short(lim_short),
    .boost_pct(boost_pct), .limit_src(limit_src), .battery_short_live(bs_live),
    .open_load_live(ol_live), .thermal_warning_live(tw_live), .supply_low_live(lo_live),
    .supply_high_live(hi_live), .battery_short_flag(bs_flag), .open_load_flag(ol_flag),
    .thermal_warning_flag(tw_flag), .supply_low_flag(lo_flag), .supply_high_flag(hi_flag),
    .output_allow(allow), .open_load_channel_select(ol_sel), .sense_select(sense_select),
    .sense_channel(sense_ch), .sense_ext_pin(sense_ext), .adc_enable(adc_en),
    .adc_done(adc_done), .adc_data(adc_data));

  dcr_host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ----------------------------------------
  // clock, watchdog and checking
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // tests need well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
    host_u.read_reg(addr, rd);
    check(rd, exp);
  endtask

  task automatic live(input logic [3:0] v, input logic [1:0] s);
    bs_live = v;
    ol_live = v;
    tw_live = v;
    lo_live = s;
    hi_live = s;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {miscompares, comparisons, cycles} = '0;
    {rst_b, wake, lim_open, lim_short, adc_done, adc_data, sense_select} = '0;
    live(4'h0, 2'h0);
    tick(3);
    rst_b = 1'b1;
    foreach (pct[k])
      expect_reg(k == 0 ? ADDR_ADC_RESULT : k == 1 ? ADDR_LIMIT_BOOST : ADDR_FAULT_MODE, 8'h00);
    for (int v = 0; v < 2; v++)
    begin
      host_u.write_reg(ADDR_LIMIT_BOOST, v ? 8'h1b : 8'he4);
      expect_reg(ADDR_LIMIT_BOOST, v ? 8'h1b : 8'he4);
      for (int i = 0; i < 4; i++)
        check({1'b0, boost_pct[i]}, pct[((v ? 8'h1b : 8'he4) >> (2 * i)) & 3]);
    end
    lim_open = 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++)
      check({limit_src[i], boost_pct[i][5:0]}, 8'h40);
    {lim_open, lim_short} = 2'b01;
    tick(2);
    for (int i = 0; i < 4; i++)
      check({limit_src[i], boost_pct[i][5:0]}, 8'hc0);
    lim_short = 1'b0;
    host_u.write_reg(ADDR_FAULT_MODE, 8'hff);
    expect_reg(ADDR_FAULT_MODE, 8'h87);
    for (int c = 0; c < 8; c++)
    begin
      host_u.write_reg(ADDR_FAULT_MODE, 8'(c));
      sense_select = 3'(c);
      tick(2);
      check({4'h0, ol_sel}, (c >= 1 && c <= 4) ? 8'h01 << (c - 1) : 8'h00);
      check({sense_ch, 2'h0, sense_ext, adc_en},
        {(c >= 1 && c <= 4) ? 4'h1 << (c - 1) : 4'h0, 2'h0, c == 5, c >= 1 && c <= 5});
    end
    sense_select = 3'h1;
    adc_data = 8'h5a;
    adc_done = 1'b1;
    tick(1);
    adc_done = 1'b0;
    adc_data = 8'ha5;
    host_u.write_reg(ADDR_ADC_RESULT, 8'h55);
    expect_reg(ADDR_ADC_RESULT, 8'h5a);
    host_u.write_reg(ADDR_FAULT_MODE, 8'h00);
    live(4'h2, 2'h1);
    tick(2);
    check({bs_flag, allow}, 8'h2d);
    check({tw_flag, lo_flag, hi_flag}, 8'h25);
    expect_reg(ADDR_DIAG_CH0 + ADDR_DIAG_STEP, 8'h00);
    check({bs_flag, ol_flag}, 8'h22);
    live(4'h0, 2'h0);
    tick(2);
    check({bs_flag, allow}, 8'h0f);
    check({tw_flag, lo_flag, hi_flag}, 8'h00);
    host_u.write_reg(ADDR_FAULT_MODE, 8'h80);
    live(4'hf, 2'h3);
    tick(1);
    live(4'h0, 2'h0);
    tick(3);
    check({bs_flag, ol_flag}, 8'hff);
    check({tw_flag, lo_flag, hi_flag}, 8'hff);
    expect_reg(ADDR_DIAG_CH0 + ADDR_DIAG_STEP, 8'h00);
    tick(1);
    check({bs_flag, ol_flag}, 8'hdd);
    check({tw_flag, lo_flag, hi_flag}, 8'hdf);
    expect_reg(ADDR_DIAG_GLOBAL, 8'h00);
    tick(1);
    check({tw_flag, lo_flag, hi_flag}, 8'hd0);
    host_u.write_reg(ADDR_LIMIT_BOOST, 8'h99);
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    expect_reg(ADDR_LIMIT_BOOST, 8'h00);
    expect_reg(ADDR_FAULT_MODE, 8'h00);
    expect_reg(ADDR_ADC_RESULT, 8'h00);
    tally_and_finish();
  end
endmodule // tb_dcr_regs
